// ==== hdl/dac_chain.sv ====
// Playback processing chain: selectable stage set per chain number.
// Assumes samples arrive from the serial audio port on the same clock.
`timescale 1ns/100ps
module dac_chain
   import chain_pkg::*;
(
   input  wire logic                i_sys_clk,
   input  wire logic                i_rstn,
   input  wire logic                i_ce,
   input  wire logic [4:0]          i_chain_sel,
   input  wire logic                i_dac_run,
   input  wire logic                i_adaptive,
   input  wire logic                i_coef_wr,
   input  wire logic [5:0]          i_coef_idx,
   input  wire logic                i_coef_byte,
   input  wire logic [7:0]          i_coef_wdata,
   input  wire logic                i_coef_rd,
   output logic      [7:0]          o_coef_rdata,
   output logic                     o_coef_locked,
   input  wire logic [SAMPLE_W-1:0] i_left,
   input  wire logic [SAMPLE_W-1:0] i_right,
   input  wire logic                i_in_valid,
   output logic                     o_in_ready,
   output logic      [SAMPLE_W-1:0] o_left,
   output logic      [SAMPLE_W-1:0] o_right,
   output logic                     o_out_valid,
   input  wire logic                i_out_ready,
   output logic      [4:0]          o_active_sel,
   output logic      [1:0]          o_interp,
   output logic      [2:0]          o_num_bq,
   output logic                     o_iir_on,
   output logic                     o_comp_on,
   output logic                     o_3d_on,
   output logic                     o_beep_on,
   output logic                     o_stereo
);
   // Chain property table; bit layout {stereo,beep,3d,comp,iir,nbq[2:0],filt[1:0]}.
   function automatic logic [9:0] chain_props(input logic [4:0] sel);
      logic [9:0] p;
      p = {1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h3, FILT_A};
      case (sel)
         5'h01: p = {1'b1, 4'h0, 3'h3, FILT_A}; // RULE1
         5'h04: p = {1'b0, 4'h0, 3'h3, FILT_A}; // RULE1
         5'h02: p = {1'b1, 4'h3, 3'h6, FILT_A}; // RULE2
         5'h05: p = {1'b0, 4'h3, 3'h6, FILT_A}; // RULE2
         5'h0a: p = {1'b1, 4'h3, 3'h6, FILT_B}; // RULE2
         5'h0f: p = {1'b0, 4'h3, 3'h6, FILT_B}; // RULE2
         5'h03: p = {1'b1, 4'h1, 3'h6, FILT_A}; // RULE3
         5'h06: p = {1'b0, 4'h1, 3'h6, FILT_A}; // RULE3
         5'h0b: p = {1'b1, 4'h1, 3'h6, FILT_B}; // RULE3
         5'h10: p = {1'b0, 4'h1, 3'h6, FILT_B}; // RULE3
         5'h07: p = {1'b1, 4'h1, 3'h0, FILT_B}; // RULE4
         5'h0c: p = {1'b0, 4'h1, 3'h0, FILT_B}; // RULE4
         5'h11: p = {1'b1, 4'h1, 3'h0, FILT_C}; // RULE4
         5'h14: p = {1'b0, 4'h1, 3'h0, FILT_C}; // RULE4
         5'h08: p = {1'b1, 4'h2, 3'h4, FILT_B}; // RULE5
         5'h0d: p = {1'b0, 4'h2, 3'h4, FILT_B}; // RULE5
         5'h09: p = {1'b1, 4'h0, 3'h4, FILT_B}; // RULE6
         5'h0e: p = {1'b0, 4'h0, 3'h4, FILT_B}; // RULE6
         5'h12: p = {1'b1, 4'h3, 3'h4, FILT_C}; // RULE7
         5'h15: p = {1'b0, 4'h3, 3'h4, FILT_C}; // RULE7
         5'h13: p = {1'b1, 4'h1, 3'h4, FILT_C}; // RULE8
         5'h16: p = {1'b0, 4'h1, 3'h4, FILT_C}; // RULE8
         5'h17: p = {1'b1, 4'h4, 3'h2, FILT_A}; // RULE9
         5'h18: p = {1'b1, 4'h7, 3'h5, FILT_A}; // RULE10
         5'h19: p = {1'b1, 4'hf, 3'h5, FILT_A}; // RULE11
         default: p = {1'b1, 4'h0, 3'h3, FILT_A};
      endcase
      return p;
   endfunction : chain_props

   // Q1.15 multiply, truncated toward minus infinity; minus one squared wraps.
   function automatic logic [SAMPLE_W-1:0] qmul(input logic [15:0] a, input logic [15:0] b);
      logic signed [31:0] m;
      m = $signed(a) * $signed(b);
      return m[30:15];
   endfunction : qmul

   function automatic logic [SAMPLE_W-1:0] sat_add(input logic [15:0] a,
                                                   input logic [15:0] b);
      logic signed [16:0] s;
      s = $signed({a[15], a}) + $signed({b[15], b});
      if (s > 17'sh07fff)       return 16'h7fff;
      else if (s < -17'sh08000) return 16'h8000;
      else                      return s[15:0];
   endfunction : sat_add

   logic [4:0]  sel_r;
   logic [9:0]  props;
   logic        locked;
   logic [COEF_W-1:0] coef_r [COEF_NUM];
   logic [7:0]  rdata_r;

   // Selection is sampled only while stopped; a live change would glitch the stream.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) sel_r <= SEL_RESET;
      else if (i_ce && !i_dac_run && i_chain_sel >= 5'h01 && i_chain_sel <= 5'h19)
         sel_r <= i_chain_sel; // RULE16
   end
   assign props        = chain_props(sel_r); // RULE13
   assign o_active_sel = sel_r;
   assign o_interp     = props[1:0];
   assign o_num_bq     = props[4:2];
   assign o_iir_on     = props[5];
   assign o_comp_on    = props[6];
   assign o_3d_on      = props[7];
   assign o_beep_on    = props[8];
   assign o_stereo     = props[9];

   assign locked        = i_dac_run && !i_adaptive; // RULE14
   assign o_coef_locked = locked;

   // Two bytes per coefficient, high byte at byte 0.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int k = 0; k < COEF_NUM; k++) begin
            coef_r[k] <= (k % COEF_PER_BQ == 0 && k < MAX_BQ*COEF_PER_BQ) ||
                         k == MAX_BQ*COEF_PER_BQ ? COEF_UNITY : COEF_ZERO;
         end
         rdata_r <= 8'h00;
      end else if (i_ce && !locked && i_coef_idx < 6'(COEF_NUM)) begin
         if (i_coef_wr) begin
            if (i_coef_byte) coef_r[i_coef_idx][7:0]  <= i_coef_wdata; // RULE15
            else             coef_r[i_coef_idx][15:8] <= i_coef_wdata; // RULE15
         end
         if (i_coef_rd)
            rdata_r <= i_coef_byte ? coef_r[i_coef_idx][7:0] : coef_r[i_coef_idx][15:8];
      end
   end
   assign o_coef_rdata = rdata_r;

   // Input FIFO buffers samples while the stage pipeline is busy.
   logic [2*SAMPLE_W-1:0] f_data;
   logic                  f_valid;
   logic                  f_ready;
   sample_fifo #(.WIDTH(2*SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_ce      (i_ce),
      .i_data    ({i_left, i_right}),
      .i_valid   (i_in_valid),
      .o_ready   (o_in_ready),
      .o_data    (f_data),
      .o_valid   (f_valid),
      .i_ready   (f_ready)
   );

   // One stage per cycle: 0 IIR, 1..6 biquads, 7 compress/3D, 8 beep and output.
   logic [3:0]          stg_r;
   logic                busy_r;
   logic [SAMPLE_W-1:0] acc_r [2];
   logic [SAMPLE_W-1:0] x1_r  [2][MAX_BQ+1];
   logic [SAMPLE_W-1:0] x2_r  [2][MAX_BQ];
   logic [SAMPLE_W-1:0] y1_r  [2][MAX_BQ+1];
   logic [SAMPLE_W-1:0] y2_r  [2][MAX_BQ];
   logic [5:0]          beep_cnt_r;
   logic                beep_ph_r;
   logic                out_v_r;

   // Halving loud samples is a cheap stand-in for a gain curve; it may pump audibly.
   function automatic logic [SAMPLE_W-1:0] squash(input logic [15:0] x, input logic on);
      return (on && x[15] != x[14]) ? {x[15], x[15:1]} : x;
   endfunction : squash
   wire [SAMPLE_W-1:0] cmp_l = squash(acc_r[0], o_comp_on);
   wire [SAMPLE_W-1:0] cmp_r = squash(acc_r[1], o_comp_on);

   assign f_ready     = !busy_r && !out_v_r;
   assign o_out_valid = out_v_r;

   // Stage output for channel c at current stage, using host coefficients.
   function automatic logic [SAMPLE_W-1:0] stage_out(input logic [15:0] x,
      input logic [15:0] x1, input logic [15:0] x2, input logic [15:0] y1,
      input logic [15:0] y2, input logic [15:0] n0, input logic [15:0] n1,
      input logic [15:0] n2, input logic [15:0] d1, input logic [15:0] d2,
      input logic bq);
      logic [15:0] s;
      s = sat_add(qmul(n0, x), qmul(n1, x1));
      if (bq) s = sat_add(sat_add(s, qmul(n1, x1)), qmul(n2, x2));
      s = sat_add(s, qmul(d1, y1));
      if (bq) s = sat_add(sat_add(s, qmul(d1, y1)), qmul(d2, y2));
      return s;
   endfunction : stage_out

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         stg_r <= 4'h0; busy_r <= 1'b0; out_v_r <= 1'b0;
         beep_cnt_r <= 6'h00; beep_ph_r <= 1'b0;
         o_left <= '0; o_right <= '0;
         for (int c = 0; c < 2; c++) begin
            acc_r[c] <= '0;
            for (int b = 0; b <= MAX_BQ; b++) begin
               x1_r[c][b] <= '0; y1_r[c][b] <= '0;
               if (b < MAX_BQ) begin x2_r[c][b] <= '0; y2_r[c][b] <= '0; end
            end
         end
      end else if (i_ce) begin
         if (out_v_r && i_out_ready) out_v_r <= 1'b0;
         if (!busy_r && f_valid && !out_v_r) begin
            acc_r[0] <= f_data[2*SAMPLE_W-1:SAMPLE_W];
            acc_r[1] <= o_stereo ? f_data[SAMPLE_W-1:0] : '0;
            busy_r <= 1'b1;
            stg_r  <= 4'h0;
         end else if (busy_r) begin
            stg_r <= stg_r + 4'h1;
            for (int c = 0; c < 2; c++) begin
               if (stg_r == 4'h0 && o_iir_on) begin // RULE12
                  acc_r[c] <= stage_out(acc_r[c], x1_r[c][MAX_BQ], '0, y1_r[c][MAX_BQ], '0,
                     coef_r[30], coef_r[31], '0, coef_r[32], '0, 1'b0);
                  x1_r[c][MAX_BQ] <= acc_r[c];
                  y1_r[c][MAX_BQ] <= stage_out(acc_r[c], x1_r[c][MAX_BQ], '0,
                     y1_r[c][MAX_BQ], '0, coef_r[30], coef_r[31], '0, coef_r[32], '0, 1'b0);
               end
               for (int b = 0; b < MAX_BQ; b++) begin
                  if (stg_r == 4'(b+1) && 3'(b) < o_num_bq) begin // RULE12
                     acc_r[c] <= stage_out(acc_r[c], x1_r[c][b], x2_r[c][b], y1_r[c][b],
                        y2_r[c][b], coef_r[5*b], coef_r[5*b+1], coef_r[5*b+2],
                        coef_r[5*b+3], coef_r[5*b+4], 1'b1);
                     x2_r[c][b] <= x1_r[c][b];
                     x1_r[c][b] <= acc_r[c];
                     y2_r[c][b] <= y1_r[c][b];
                     y1_r[c][b] <= stage_out(acc_r[c], x1_r[c][b], x2_r[c][b],
                        y1_r[c][b], y2_r[c][b], coef_r[5*b], coef_r[5*b+1],
                        coef_r[5*b+2], coef_r[5*b+3], coef_r[5*b+4], 1'b1);
                  end
               end
            end
            if (stg_r == 4'h7) begin
               // The 3D mix works on the compressed pair so both stages take effect.
               acc_r[0] <= o_3d_on ? sat_add(cmp_l, qmul(cmp_l - cmp_r, 16'h2000))
                                   : cmp_l; // RULE10
               acc_r[1] <= o_3d_on ? sat_add(cmp_r, qmul(cmp_r - cmp_l, 16'h2000))
                                   : cmp_r; // RULE10
            end
            if (stg_r == 4'h8) begin
               busy_r <= 1'b0;
               out_v_r <= 1'b1;
               if (o_beep_on) begin
                  beep_cnt_r <= (beep_cnt_r == 6'(BEEP_HALF_PERIOD-1)) ? 6'h00
                                : beep_cnt_r + 6'h01;
                  if (beep_cnt_r == 6'(BEEP_HALF_PERIOD-1)) beep_ph_r <= !beep_ph_r;
               end
               o_left  <= o_beep_on ? sat_add(acc_r[0], beep_ph_r ? BEEP_AMPL : -BEEP_AMPL)
                                    : acc_r[0];
               o_right <= !o_stereo ? '0 : o_beep_on ?
                          sat_add(acc_r[1], beep_ph_r ? BEEP_AMPL : -BEEP_AMPL) : acc_r[1];
            end
         end
      end
   end

   wire [COEF_W-1:0] coef_at_idx = (i_coef_idx < 6'(COEF_NUM)) ? coef_r[i_coef_idx] : COEF_ZERO;
   a_lock_blocks_wr: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE14
      (locked && i_coef_wr && i_ce) |=> (i_coef_idx != $past(i_coef_idx)) || $stable(coef_at_idx))
      else $error("coefficient changed while locked");
   a_sel_frozen_run: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE16
      $past(i_dac_run) |-> $stable(sel_r))
      else $error("chain selection changed while running");
   a_chain1_props: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE1
      sel_r == 5'h01 |-> o_num_bq == 3'h3 && !o_iir_on && !o_comp_on && o_stereo)
      else $error("chain 1 properties wrong");
   a_chain2_props: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE2
      sel_r == 5'h0f |-> o_num_bq == 3'h6 && o_iir_on && o_comp_on && !o_stereo)
      else $error("chain 15 properties wrong");
   a_chain3_props: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE3
      sel_r == 5'h0b |-> o_num_bq == 3'h6 && o_iir_on && !o_comp_on && o_interp == FILT_B)
      else $error("chain 11 properties wrong");
   a_chain4_props: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE4
      sel_r == 5'h14 |-> o_num_bq == 3'h0 && o_iir_on && o_interp == FILT_C)
      else $error("chain 20 properties wrong");
   a_chain25_beep: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE11
      o_beep_on |-> sel_r == 5'h19 && o_3d_on && o_num_bq == 3'h5)
      else $error("beep outside chain 25");
   a_out_after_stages: assert property (@(posedge i_sys_clk) disable iff (!i_rstn || !i_ce) // RULE13
      $rose(busy_r) |-> ##9 $rose(out_v_r))
      else $error("output valid not raised after the stage walk");
endmodule : dac_chain

// ==== hdl/chain_pkg.sv ====
// What this block does
// (RULE1) Chains 1,4: filter A, three biquads only.
// (RULE2) Chains 2,5,10,15: IIR, six biquads, compressor.
// (RULE3) Chains 3,6,11,16: IIR, six biquads, no compressor.
// (RULE4) Chains 7,12,17,20: IIR only, no biquads.
// (RULE5) Chains 8,13: filter B, four biquads, compressor.
// (RULE6) Chains 9,14: filter B, four biquads only.
// (RULE7) Chains 18,21: filter C, IIR, four biquads, compressor.
// (RULE8) Chains 19,22: filter C, IIR, four biquads.
// (RULE9) Chain 23: filter A, two biquads, 3D.
// (RULE10) Chain 24: IIR, five biquads, compressor, 3D.
// (RULE11) Chain 25: as 24 plus beep.
// (RULE12) IIR and biquad coefficients come from host.
// (RULE13) Fixed chain set selects filter and stages.
// (RULE14) Coefficient access blocked while running, non-adaptive.
// (RULE15) Coefficients are 16-bit 1.15, two bytes.
// (RULE16) Host changes selection only while powered down.
//
// Shared constants of the playback processing chain.
// Assumes one system clock and an active-low asynchronous reset.
package chain_pkg;
   typedef enum logic [1:0] {FILT_A, FILT_B, FILT_C} interp_t;
   localparam int SAMPLE_W    = 16;
   localparam int COEF_W      = 16;
   localparam int NUM_CHAINS  = 25;
   localparam int MAX_BQ      = 6;
   localparam int COEF_PER_BQ = 5;
   localparam int COEF_IIR    = 3;
   localparam int COEF_NUM    = MAX_BQ * COEF_PER_BQ + COEF_IIR;
   localparam int FIFO_DEPTH  = 4;
   localparam logic [4:0]        SEL_RESET   = 5'h01;
   localparam logic [COEF_W-1:0] COEF_UNITY  = 16'h7fff;
   localparam logic [COEF_W-1:0] COEF_ZERO   = 16'h0000;
   localparam logic [SAMPLE_W-1:0] BEEP_AMPL = 16'h1000;
   localparam int BEEP_HALF_PERIOD = 20;
endpackage : chain_pkg

// ==== hdl/sample_fifo.sv ====
// Small sample FIFO with valid/ready on both sides.
// Assumes both sides on one clock.
`timescale 1ns/100ps
module sample_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_rstn,
   input  wire logic             i_ce,
   input  wire logic [WIDTH-1:0] i_data,
   input  wire logic             i_valid,
   output logic                  o_ready,
   output logic      [WIDTH-1:0] o_data,
   output logic                  o_valid,
   input  wire logic             i_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   wire              push = i_valid && o_ready && i_ce;
   wire              pop  = o_valid && i_ready && i_ce;
   assign o_ready = (cnt_r < (AW+1)'(DEPTH));
   assign o_valid = (cnt_r != '0);
   assign o_data  = mem[rp_r];
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem[wp_r] <= i_data;
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         if (pop)  rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : sample_fifo

// ==== tb/sample_partner.sv ====
// Far-side model: a serial audio source and a modulator sink.
// Assumes the chain's clock; drives source and ready at the falling edge, updates received count and data at the rising edge.
`timescale 1ns/100ps
module sample_partner
   import chain_pkg::*;
(
   input  wire logic                i_sys_clk,
   input  wire logic                i_ce,
   input  wire logic [7:0]          i_num,
   input  wire logic                i_slow,
   input  wire logic                i_in_ready,
   output logic      [SAMPLE_W-1:0] o_src_l,
   output logic      [SAMPLE_W-1:0] o_src_r,
   output logic                     o_src_valid,
   input  wire logic [SAMPLE_W-1:0] i_snk_l,
   input  wire logic [SAMPLE_W-1:0] i_snk_r,
   input  wire logic                i_snk_valid,
   output logic                     o_snk_ready,
   output logic      [7:0]          o_tx_cnt,
   output logic      [7:0]          o_rx_cnt,
   output logic      [SAMPLE_W-1:0] o_got_l,
   output logic      [SAMPLE_W-1:0] o_got_r
);
   logic       took;
   logic [3:0] phase;
   initial begin
      {o_src_l, o_src_r, o_src_valid, o_snk_ready, o_tx_cnt, o_rx_cnt} = '0;
      {o_got_l, o_got_r, took, phase} = '0;
   end
   always @(posedge i_sys_clk) begin
      took <= o_src_valid && i_in_ready && i_ce;
      if (i_snk_valid && o_snk_ready && i_ce) begin
         o_rx_cnt <= o_rx_cnt + 8'h01;
         o_got_l  <= i_snk_l;
         o_got_r  <= i_snk_r;
      end
   end
   // A slow sink stalls half the time so the FIFO backs up.
   always @(negedge i_sys_clk) begin
      phase = phase + 4'h1;
      o_snk_ready = !(i_slow && phase[1]);
      if (took) o_tx_cnt = o_tx_cnt + 8'h01;
      if (o_tx_cnt != i_num) begin
         o_src_valid = 1'b1;
         o_src_l = {8'h04, o_tx_cnt};
         o_src_r = {8'h08, o_tx_cnt};
      end else begin
         // Idle lines change every cycle so stale data never looks valid.
         o_src_valid = 1'b0;
         o_src_l = ~o_src_l;
         o_src_r = ~o_src_r;
      end
   end
endmodule : sample_partner

// ==== tb/tb_dac_processing_block_chain.sv ====
// Self-checking bench for the playback chain selector.
// Assumes the far-side model drives samples and takes results.
`timescale 1ns/100ps
module tb_dac_processing_block_chain;
   import chain_pkg::*;
   logic i_sys_clk, i_rstn, i_ce, i_dac_run, i_adaptive, i_coef_wr, i_coef_byte, i_coef_rd;
   logic i_in_valid, i_out_ready, slow;
   logic [4:0] i_chain_sel;
   logic [5:0] i_coef_idx;
   logic [7:0] i_coef_wdata, num;
   logic [SAMPLE_W-1:0] i_left, i_right;
   wire logic [7:0] o_coef_rdata, tx_cnt, rx_cnt;
   wire logic o_coef_locked, o_in_ready, o_out_valid, o_iir_on, o_comp_on, o_3d_on;
   wire logic o_beep_on, o_stereo;
   wire logic [SAMPLE_W-1:0] o_left, o_right, got_l, got_r;
   wire logic [4:0] o_active_sel;
   wire logic [1:0] o_interp;
   wire logic [2:0] o_num_bq;
   int n_mismatch, cmp_count;
   dac_chain dac_chain_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(i_ce),
      .i_chain_sel(i_chain_sel), .i_dac_run(i_dac_run), .i_adaptive(i_adaptive),
      .i_coef_wr(i_coef_wr), .i_coef_idx(i_coef_idx), .i_coef_byte(i_coef_byte),
      .i_coef_wdata(i_coef_wdata), .i_coef_rd(i_coef_rd), .o_coef_rdata(o_coef_rdata),
      .o_coef_locked(o_coef_locked), .i_left(i_left), .i_right(i_right),
      .i_in_valid(i_in_valid), .o_in_ready(o_in_ready), .o_left(o_left), .o_right(o_right),
      .o_out_valid(o_out_valid), .i_out_ready(i_out_ready), .o_active_sel(o_active_sel),
      .o_interp(o_interp), .o_num_bq(o_num_bq), .o_iir_on(o_iir_on), .o_comp_on(o_comp_on),
      .o_3d_on(o_3d_on), .o_beep_on(o_beep_on), .o_stereo(o_stereo));
   sample_partner sample_partner_i (.i_sys_clk(i_sys_clk), .i_ce(i_ce), .i_num(num),
      .i_slow(slow), .i_in_ready(o_in_ready), .o_src_l(i_left), .o_src_r(i_right),
      .o_src_valid(i_in_valid), .i_snk_l(o_left), .i_snk_r(o_right),
      .i_snk_valid(o_out_valid), .o_snk_ready(i_out_ready), .o_tx_cnt(tx_cnt),
      .o_rx_cnt(rx_cnt), .o_got_l(got_l), .o_got_r(got_r));
   always #12.5 i_sys_clk = ~i_sys_clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done;
      if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   // Stage set of each chain: filter, stereo, IIR, biquads, compressor, 3D, beep.
   function automatic logic [9:0] exp_row(input int n);
      logic [1:0] f;
      logic [2:0] b;
      f = (n inside {[7:16]}) ? 2'h1 : (n inside {[17:22]}) ? 2'h2 : 2'h0;
      b = (n inside {1, 4}) ? 3'h3 : (n inside {7, 12, 17, 20}) ? 3'h0 : (n == 23) ? 3'h2 :
          (n > 23) ? 3'h5 : (n inside {8, 9, 13, 14, 18, 19, 21, 22}) ? 3'h4 : 3'h6;
      return {f, n inside {[1:3], [7:11], [17:19], [23:25]},
              !(n inside {1, 4, 8, 9, 13, 14, 23}), b,
              n inside {2, 5, 8, 10, 13, 15, 18, 21, 24, 25}, n > 22, n == 25};
   endfunction : exp_row
   task automatic set_sel(input logic [4:0] n);
      i_chain_sel = n;
      repeat (2) @(negedge i_sys_clk);
   endtask : set_sel
   task automatic coef_wr(input logic [5:0] idx, input logic [15:0] val);
      {i_coef_idx, i_coef_byte, i_coef_wdata, i_coef_wr} = {idx, 1'b0, val[15:8], 1'b1};
      @(negedge i_sys_clk);
      {i_coef_byte, i_coef_wdata} = {1'b1, val[7:0]};
      @(negedge i_sys_clk);
      i_coef_wr = 1'b0;
      @(negedge i_sys_clk);
   endtask : coef_wr
   task automatic coef_rd(input logic [5:0] idx, output logic [15:0] val);
      {i_coef_idx, i_coef_byte, i_coef_rd} = {idx, 1'b0, 1'b1};
      @(negedge i_sys_clk);
      val[15:8] = o_coef_rdata;
      i_coef_byte = 1'b1;
      @(negedge i_sys_clk);
      val[7:0] = o_coef_rdata;
      i_coef_rd = 1'b0;
      @(negedge i_sys_clk);
   endtask : coef_rd
   // Selection changes only while stopped, then samples run through.
   task automatic stream(input logic [4:0] n, input logic [7:0] cnt, input logic slw);
      logic [7:0] tgt;
      logic       full;
      i_dac_run = 1'b0;
      set_sel(n);
      {i_dac_run, slow, full} = {1'b1, slw, 1'b0};
      tgt = rx_cnt + cnt;
      num = tx_cnt + cnt;
      for (int k = 0; k < 3000 && rx_cnt !== tgt; k++) begin
         @(negedge i_sys_clk);
         if (o_in_ready === 1'b0) full = 1'b1;
      end
      if (rx_cnt !== tgt) begin
         n_mismatch++;
         test_done();
      end
      check(tx_cnt, num);
      if (slw) check(full, 1'b1);
      i_dac_run = 1'b0;
   endtask : stream
   task automatic t_reset;
      logic [15:0] v;
      check(o_active_sel, SEL_RESET);
      check(o_coef_locked, 1'b0);
      coef_rd(6'h00, v);
      check(v, COEF_UNITY);
      coef_rd(6'h01, v);
      check(v, COEF_ZERO);
      coef_rd(6'h1e, v);
      check(v, COEF_UNITY);
   endtask : t_reset
   task automatic t_table;
      for (int n = 1; n <= 25; n++) begin
         set_sel(n[4:0]);
         check(o_active_sel, n[4:0]);
         check({o_interp, o_stereo, o_iir_on, o_num_bq, o_comp_on, o_3d_on, o_beep_on},
               exp_row(n));
      end
      set_sel(5'h00);
      check(o_active_sel, 5'h19);
      set_sel(5'h1a);
      check(o_active_sel, 5'h19);
   endtask : t_table
   task automatic t_lock;
      logic [15:0] v;
      coef_wr(6'h05, 16'h1234);
      coef_rd(6'h05, v);
      check(v, 16'h1234);
      i_dac_run = 1'b1;
      set_sel(5'h09);
      check(o_active_sel, 5'h19);
      check(o_coef_locked, 1'b1);
      coef_wr(6'h05, 16'hbeef);
      i_adaptive = 1'b1;
      @(negedge i_sys_clk);
      check(o_coef_locked, 1'b0);
      coef_rd(6'h05, v);
      check(v, 16'h1234);
      coef_wr(6'h05, 16'h8001);
      coef_rd(6'h05, v);
      check(v, 16'h8001);
      coef_wr(6'h05, COEF_UNITY);
      {i_dac_run, i_adaptive} = 2'b00;
      i_ce = 1'b0;
      coef_wr(6'h05, 16'h4321);
      i_ce = 1'b1;
      coef_rd(6'h05, v);
      check(v, COEF_UNITY);
   endtask : t_lock
   task automatic t_coef_path;
      coef_wr(6'h00, COEF_ZERO);
      stream(5'h01, 8'h08, 1'b1);
      check(got_l, 16'h0000);
      check(got_r, 16'h0000);
      stream(5'h07, 8'h04, 1'b0);
      check(got_l == 16'h0000, 1'b0);
      check(got_r == 16'h0000, 1'b0);
      coef_wr(6'h1e, COEF_ZERO);
      stream(5'h07, 8'h04, 1'b0);
      check(got_l, 16'h0000);
   endtask : t_coef_path
   task automatic t_left_only;
      coef_wr(6'h00, COEF_UNITY);
      coef_wr(6'h1e, COEF_UNITY);
      stream(5'h0c, 8'h04, 1'b0);
      check(got_l == 16'h0000, 1'b0);
      check(got_r, 16'h0000);
   endtask : t_left_only
   // With the IIR input gain zeroed, only the tone is left, which starts on its low half.
   task automatic t_beep;
      logic [15:0] e;
      e = -BEEP_AMPL;
      coef_wr(6'h1e, COEF_ZERO);
      stream(5'h19, 8'h04, 1'b0);
      check(got_l, e);
      check(got_r, e);
   endtask : t_beep
   initial begin
      {i_sys_clk, i_rstn, i_ce, i_dac_run, i_adaptive} = 5'b00100;
      {i_coef_wr, i_coef_byte, i_coef_rd, slow, num} = '0;
      {i_chain_sel, i_coef_idx, i_coef_wdata} = '0;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (16) @(negedge i_sys_clk);
      i_rstn = 1'b1;
      @(negedge i_sys_clk);
      t_reset();
      t_table();
      t_lock();
      t_coef_path();
      t_left_only();
      t_beep();
      test_done();
   end
endmodule : tb_dac_processing_block_chain
